// ---- hw/lbam_monitor.sv ----
// Lamp ballast alarm monitor: temperature limits, filtered switches, feedback timeouts.
// Assumes inputs synchronous to clk_in and temperatures as signed whole degrees C.
//
// Summary of operation
// - Die warn above 75C, fault above 85C
// - Board warning above 65C
// - Board fault above 75C
// - Exhaust warn setpoint+10, fault setpoint+20
// - Interlock change accepted after 300 ms
// - Thermal switch open recognised after 300 ms
// - Shutter mismatch beyond 2 s faults
// - Blower feedback absent after 2 s faults
// - Pressure/flow condition beyond 2 s faults
// - Lamp ready missing after 180 s faults
// - Fault: lamp off, cooldown if warming or on, alarm high
`timescale 1ns/1ps
module lbam_monitor
    import lbam_pkg::*;
#(
    parameter int unsigned TICK_CLKS      = TICK_CYCLES,
    parameter int unsigned INTERLOCK_MS   = INTERLOCK_FILTER_MS,
    parameter int unsigned THERMAL_MS     = THERMAL_SWITCH_FILTER_MS,
    parameter int unsigned SHUTTER_MS     = SHUTTER_LIMIT_MS,
    parameter int unsigned BLOWER_MS      = BLOWER_FEEDBACK_LIMIT_MS,
    parameter int unsigned AIRFLOW_MS     = AIRFLOW_FAULT_LIMIT_MS,
    parameter int unsigned WARMUP_MS      = WARMUP_TIME_LIMIT_MS
) (
    input  wire logic               clk_in,
    input  wire logic               reset_n_in,
    input  wire logic signed [9:0]  die_a_temp_in,
    input  wire logic signed [9:0]  die_b_temp_in,
    input  wire logic signed [9:0]  board_temp_in,
    input  wire logic signed [9:0]  exhaust_temp_in,
    input  wire logic signed [9:0]  lamp_setpoint_in,
    input  wire logic               cassette_locked_in,
    input  wire logic               thermal_switch_closed_in,
    input  wire logic               shutter_cmd_in,
    input  wire logic               shutter_pos_in,
    input  wire logic               blower_on_in,
    input  wire logic               blower_feedback_in,
    input  wire logic               airflow_fault_in,
    input  wire logic               lamp_start_in,
    input  wire logic               lamp_ready_in,
    input  wire logic               cooldown_done_in,
    input  wire logic               fault_clear_in,
    output lbam_warn_s              warn_out,
    output lbam_fault_s             fault_out,
    output logic                    lamp_enable_out,
    output logic                    cooldown_out,
    output logic                    alarm_out
);
    // Reset release through two flops
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    logic tick;

    lbam_tick #(
        .CYCLES   (TICK_CLKS)
    ) u_tick (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_q),
        .tick_out (tick)
    );

    // Interlock filter: state follows input only after it stays different 300 ms
    logic locked_q;
    logic locked_d;
    logic lock_change_done;

    lbam_timer #(
        .LIMIT       (INTERLOCK_MS)
    ) u_lock (
        .clk_in      (clk_in),
        .rst_n_in    (rst_n_q),
        .tick_in     (tick),
        .cond_in     (cassette_locked_in != locked_q),
        .expired_out (lock_change_done)
    );

    always_comb begin
        locked_d = lock_change_done ? cassette_locked_in : locked_q;
    end

    // Timed conditions
    logic therm_open;
    logic shutter_to;
    logic blower_to;
    logic airflow_to;
    logic warmup_to;
    lbam_lamp_e lamp_q;
    lbam_lamp_e lamp_d;

    lbam_timer #(
        .LIMIT       (THERMAL_MS)
    ) u_therm (
        .clk_in      (clk_in),
        .rst_n_in    (rst_n_q),
        .tick_in     (tick),
        .cond_in     (!thermal_switch_closed_in),
        .expired_out (therm_open)
    );

    lbam_timer #(
        .LIMIT       (SHUTTER_MS)
    ) u_shutter (
        .clk_in      (clk_in),
        .rst_n_in    (rst_n_q),
        .tick_in     (tick),
        .cond_in     (shutter_cmd_in != shutter_pos_in),
        .expired_out (shutter_to)
    );

    lbam_timer #(
        .LIMIT       (BLOWER_MS)
    ) u_blower (
        .clk_in      (clk_in),
        .rst_n_in    (rst_n_q),
        .tick_in     (tick),
        .cond_in     (blower_on_in && !blower_feedback_in),
        .expired_out (blower_to)
    );

    lbam_timer #(
        .LIMIT       (AIRFLOW_MS)
    ) u_airflow (
        .clk_in      (clk_in),
        .rst_n_in    (rst_n_q),
        .tick_in     (tick),
        .cond_in     (airflow_fault_in),
        .expired_out (airflow_to)
    );

    lbam_timer #(
        .LIMIT       (WARMUP_MS)
    ) u_warmup (
        .clk_in      (clk_in),
        .rst_n_in    (rst_n_q),
        .tick_in     (tick),
        .cond_in     (lamp_q == LBAM_LAMP_WARM && !lamp_ready_in),
        .expired_out (warmup_to)
    );

    // Temperature comparisons; exhaust limit widened so setpoint+20 cannot wrap
    logic signed [10:0] exh_wide;
    logic signed [10:0] sp_wide;
    lbam_warn_s         warn_now;
    lbam_fault_s        fault_now;

    always_comb begin
        exh_wide = {exhaust_temp_in[9], exhaust_temp_in};
        sp_wide  = {lamp_setpoint_in[9], lamp_setpoint_in};
        warn_now.die_warn     = (die_a_temp_in > DIE_WARN_LIMIT)
                              || (die_b_temp_in > DIE_WARN_LIMIT);
        warn_now.board_warn   = board_temp_in > BOARD_WARN_LIMIT;
        warn_now.exhaust_warn = exh_wide > sp_wide + EXHAUST_WARN_OFFSET;
        fault_now.die_fault   = (die_a_temp_in > DIE_FAULT_LIMIT)
                              || (die_b_temp_in > DIE_FAULT_LIMIT);
        fault_now.board_fault = board_temp_in > BOARD_FAULT_LIMIT;
        fault_now.exhaust_fault = exh_wide > sp_wide + EXHAUST_FAULT_OFFSET;
        fault_now.cassette_unlocked = !locked_q;
        fault_now.cassette_overtemp = therm_open;
        fault_now.shutter_fault     = shutter_to;
        fault_now.blower_fault      = blower_to;
        fault_now.airflow_fault     = airflow_to;
        fault_now.warmup_fault      = warmup_to;
    end

    // Warnings are live levels; faults latch, set beats clear
    lbam_warn_s  warn_q;
    lbam_fault_s fault_q;
    lbam_fault_s fault_d;
    logic        alarm_q;
    logic        alarm_d;
    logic        any_fault;

    always_comb begin
        fault_d   = fault_clear_in ? fault_now : (fault_q | fault_now);
        any_fault = |fault_now || |fault_q;
        alarm_d   = |fault_d;
    end

    // Lamp sequencing: faults force cooldown from warm or on and block a start from off, warnings are ignored here
    always_comb begin
        lamp_d = lamp_q;
        case (lamp_q)
            LBAM_LAMP_OFF: begin
                if (lamp_start_in && !any_fault) begin
                    lamp_d = LBAM_LAMP_WARM;
                end
            end
            LBAM_LAMP_WARM: begin
                if (any_fault) begin
                    lamp_d = LBAM_LAMP_COOL;
                end else if (!lamp_start_in) begin
                    lamp_d = LBAM_LAMP_COOL;
                end else if (lamp_ready_in) begin
                    lamp_d = LBAM_LAMP_ON;
                end
            end
            LBAM_LAMP_ON: begin
                if (any_fault || !lamp_start_in) begin
                    lamp_d = LBAM_LAMP_COOL;
                end
            end
            LBAM_LAMP_COOL: begin
                if (cooldown_done_in) begin
                    lamp_d = LBAM_LAMP_OFF;
                end
            end
            default: lamp_d = LBAM_LAMP_OFF;
        endcase
    end

    // Outputs registered; enable drops in the same edge a fault is latched
    logic lamp_en_q;
    logic lamp_en_d;
    logic cool_q;
    logic cool_d;

    always_comb begin
        lamp_en_d = (lamp_d == LBAM_LAMP_WARM || lamp_d == LBAM_LAMP_ON)
                  && !(|fault_d);
        cool_d    = lamp_d == LBAM_LAMP_COOL;
    end

    always_ff @(posedge clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            locked_q  <= 1'b0;
            warn_q    <= '0;
            fault_q   <= '0;
            alarm_q   <= 1'b0;
            lamp_q    <= LBAM_LAMP_OFF;
            lamp_en_q <= 1'b0;
            cool_q    <= 1'b0;
        end else begin
            locked_q  <= locked_d;
            warn_q    <= warn_now;
            fault_q   <= fault_d;
            alarm_q   <= alarm_d;
            lamp_q    <= lamp_d;
            lamp_en_q <= lamp_en_d;
            cool_q    <= cool_d;
        end
    end

    assign warn_out        = warn_q;
    assign fault_out       = fault_q;
    assign lamp_enable_out = lamp_en_q;
    assign cooldown_out    = cool_q;
    assign alarm_out       = alarm_q;
endmodule

// ---- shared/lbam_pkg.sv ----
// Package for the lamp ballast alarm monitor: thresholds, timeouts, alarm carriers.
// Assumes a 200 MHz system clock and temperatures in whole degrees C, signed 10 bit.
package lbam_pkg;

    localparam int unsigned CLK_HZ          = 200_000_000;
    localparam int unsigned TEMP_W          = 10;

    // Temperature limits, degrees C
    localparam logic signed [9:0] DIE_WARN_LIMIT       = 10'sd75;
    localparam logic signed [9:0] DIE_FAULT_LIMIT      = 10'sd85;
    localparam logic signed [9:0] BOARD_WARN_LIMIT     = 10'sd65;
    localparam logic signed [9:0] BOARD_FAULT_LIMIT    = 10'sd75;
    localparam logic signed [10:0] EXHAUST_WARN_OFFSET  = 11'sd10;
    localparam logic signed [10:0] EXHAUST_FAULT_OFFSET = 11'sd20;

    // Timebase: one tick per millisecond
    localparam int unsigned TICK_MS         = 1;
    localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;

    // Timeouts in milliseconds, counted in ticks
    localparam int unsigned INTERLOCK_FILTER_MS     = 300;
    localparam int unsigned THERMAL_SWITCH_FILTER_MS = 300;
    localparam int unsigned SHUTTER_LIMIT_MS        = 2000;
    localparam int unsigned BLOWER_FEEDBACK_LIMIT_MS = 2000;
    localparam int unsigned AIRFLOW_FAULT_LIMIT_MS  = 2000;
    localparam int unsigned WARMUP_TIME_LIMIT_MS    = 180_000;

    localparam int unsigned TIMER_W         = 18;

    typedef struct packed {
        logic die_warn;
        logic board_warn;
        logic exhaust_warn;
    } lbam_warn_s;

    typedef struct packed {
        logic die_fault;
        logic board_fault;
        logic exhaust_fault;
        logic cassette_unlocked;
        logic cassette_overtemp;
        logic shutter_fault;
        logic blower_fault;
        logic airflow_fault;
        logic warmup_fault;
    } lbam_fault_s;

    typedef enum logic [1:0] {
        LBAM_LAMP_OFF  = 2'b00,
        LBAM_LAMP_WARM = 2'b01,
        LBAM_LAMP_ON   = 2'b10,
        LBAM_LAMP_COOL = 2'b11
    } lbam_lamp_e;

endpackage

// ---- hw/lbam_tick.sv ----
// Common timebase: one pulse every TICK cycles.
// Assumes an asynchronous active-low reset already conditioned by the top.
`timescale 1ns/1ps
module lbam_tick
    import lbam_pkg::*;
#(
    parameter int unsigned CYCLES = TICK_CYCLES
) (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    output logic      tick_out
);
    initial begin
        if (CYCLES < 2) $error("lbam_tick: CYCLES must be at least 2");
    end

    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic        tick_q;
    logic        tick_d;

    always_comb begin
        tick_d = (cnt_q == CYCLES - 1);
        cnt_d  = tick_d ? 32'h0 : cnt_q + 32'h1;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q  <= 32'h0;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick_out = tick_q;
endmodule

// ---- hw/lbam_timer.sv ----
// Persistence timer: expired rises once cond_in held for LIMIT ticks.
// Restarts from zero the moment cond_in drops; tick_in is the shared timebase.
`timescale 1ns/1ps
module lbam_timer
    import lbam_pkg::*;
#(
    parameter int unsigned LIMIT = 300
) (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic tick_in,
    input  wire logic cond_in,
    output logic      expired_out
);
    initial begin
        if (LIMIT < 1 || LIMIT >= (1 << TIMER_W)) $error("lbam_timer: LIMIT out of range");
    end

    localparam logic [TIMER_W-1:0] LIM = TIMER_W'(LIMIT);

    logic [TIMER_W-1:0] cnt_q;
    logic [TIMER_W-1:0] cnt_d;

    always_comb begin
        if (!cond_in) begin
            cnt_d = '0;
        end else if (tick_in && cnt_q != LIM) begin
            cnt_d = cnt_q + TIMER_W'(1);
        end else begin
            cnt_d = cnt_q;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign expired_out = cond_in && (cnt_q == LIM);
endmodule

// ---- tb/lbam_checker.sv ----
// Checker for the alarm monitor, bound to its top module.
// Assumes one-cycle registered outputs and a two-edge internal reset.
`timescale 1ns/1ps
module lbam_checker
    import lbam_pkg::*;
(
    input wire logic              clk_in,
    input wire logic              reset_n_in,
    input wire logic signed [9:0] die_a_temp_in,
    input wire logic signed [9:0] die_b_temp_in,
    input wire logic signed [9:0] board_temp_in,
    input wire logic signed [9:0] exhaust_temp_in,
    input wire logic signed [9:0] lamp_setpoint_in,
    input wire logic              airflow_fault_in,
    input wire logic              lamp_start_in,
    input wire logic              fault_clear_in,
    input wire lbam_warn_s        warn_out,
    input wire lbam_fault_s       fault_out,
    input wire logic              lamp_enable_out,
    input wire logic              cooldown_out,
    input wire logic              alarm_out
);
    logic [1:0] age_q;
    logic [1:0] age_d;
    // Internal reset lags the pin, so hold off until the copy is released
    always_comb age_d = (age_q == 2'h3) ? age_q : age_q + 2'h1;
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) age_q <= 2'h0;
        else age_q <= age_d;
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in || age_q != 2'h3);
    sequence shut_s;
        !lamp_enable_out ##1 cooldown_out;
    endsequence
    chk_die_warn: assert property (warn_out.die_warn ==
        $past(die_a_temp_in > DIE_WARN_LIMIT || die_b_temp_in > DIE_WARN_LIMIT))
        else $error("die warning wrong");
    chk_die_fault: assert property (die_a_temp_in > DIE_FAULT_LIMIT ||
        die_b_temp_in > DIE_FAULT_LIMIT |=> fault_out.die_fault) else $error("die fault missed");
    chk_board_warn: assert property (warn_out.board_warn ==
        $past(board_temp_in > BOARD_WARN_LIMIT)) else $error("board warning wrong");
    chk_board_fault: assert property (board_temp_in > BOARD_FAULT_LIMIT
        |=> fault_out.board_fault) else $error("board fault missed");
    chk_exhaust_warn: assert property (warn_out.exhaust_warn == $past(int'(exhaust_temp_in) >
        int'(lamp_setpoint_in) + int'(EXHAUST_WARN_OFFSET))) else $error("exhaust warning wrong");
    chk_alarm_any: assert property (alarm_out == (|fault_out))
        else $error("alarm not tied to faults");
    chk_fault_shut: assert property ($rose(alarm_out) && $past(lamp_enable_out)
        |-> shut_s) else $error("lamp not shut on fault");
    chk_warn_lamp: assert property ($fell(lamp_enable_out)
        |-> alarm_out || !$past(lamp_start_in)) else $error("lamp dropped without fault");
    chk_fault_latch: assert property ($fell(alarm_out) |-> $past(fault_clear_in))
        else $error("fault dropped without clear");
    chk_airflow_hold: assert property ($rose(fault_out.airflow_fault)
        |-> $past(airflow_fault_in, 2) && $past(airflow_fault_in, 12))
        else $error("airflow fault too early");
endmodule
bind lbam_monitor lbam_checker chk (.clk_in, .reset_n_in, .die_a_temp_in, .die_b_temp_in,
    .board_temp_in, .exhaust_temp_in, .lamp_setpoint_in, .airflow_fault_in, .lamp_start_in,
    .fault_clear_in, .warn_out, .fault_out, .lamp_enable_out, .cooldown_out, .alarm_out);

// ---- tb/lbam_partner.sv ----
// Far-side model: blower, shutter and lamp answer their commands.
// Assumes lazy bits, set by the bench, hold an answer back past every timeout.
`timescale 1ns/1ps
module lbam_partner (
    input  wire logic       clk_in,
    input  wire logic [2:0] lazy_in,
    input  wire logic       blower_on_in,
    input  wire logic       shutter_cmd_in,
    input  wire logic       lamp_start_in,
    output logic            blower_feedback_out,
    output logic            shutter_pos_out,
    output logic            lamp_ready_out
);
    logic [2:0] want;
    logic [2:0] have = 3'h0;
    int         n [3] = '{0, 0, 0};
    assign want = {blower_on_in, shutter_cmd_in, lamp_start_in};
    assign {blower_feedback_out, shutter_pos_out, lamp_ready_out} = have;
    always_ff @(posedge clk_in) begin
        for (int i = 0; i < 3; i++) begin
            n[i] <= (want[i] == have[i]) ? 0 : n[i] + 1;
            // Compare with >= so a cleared lazy bit still lets a long-held answer through
            if (n[i] >= (lazy_in[i] ? 10000 : 3)) have[i] <= want[i];
        end
    end
endmodule

// ---- tb/lamp_ballast_alarm_monitor_bench.sv ----
// Bench for the alarm monitor with shortened counts.
// Assumes the partner model answers blower, shutter and lamp.
`timescale 1ns/1ps
module lamp_ballast_alarm_monitor_bench;
    import lbam_pkg::*;
    logic clk_in = 0, reset_n_in = 0, locked = 1, closed = 1, sh_cmd = 0, bl_on = 0;
    logic air = 0, start = 0, cool_done = 0, clear = 0, sh_pos, bl_fb, ready, lamp_en, cool, alarm;
    logic [2:0]        lazy = 3'h0;
    logic signed [9:0] temp [4] = '{10'sd25, 10'sd25, 10'sd25, 10'sd90};
    logic signed [9:0] sp = 10'sd100;
    lbam_warn_s        warn;
    lbam_fault_s       fault;
    int                n_fail = 0, n_tests = 0;
    always #2.5 clk_in = ~clk_in;
    lbam_partner far (.clk_in(clk_in), .lazy_in(lazy), .blower_on_in(bl_on),
        .shutter_cmd_in(sh_cmd), .lamp_start_in(start), .blower_feedback_out(bl_fb),
        .shutter_pos_out(sh_pos), .lamp_ready_out(ready));
    // Shutter and blower keep their full 2000-tick limits
    lbam_monitor #(.TICK_CLKS(4), .INTERLOCK_MS(3), .THERMAL_MS(3), .AIRFLOW_MS(5),
        .WARMUP_MS(8)) uut (.clk_in(clk_in),
        .reset_n_in(reset_n_in), .die_a_temp_in(temp[0]), .die_b_temp_in(temp[1]),
        .board_temp_in(temp[2]), .exhaust_temp_in(temp[3]), .lamp_setpoint_in(sp),
        .cassette_locked_in(locked), .thermal_switch_closed_in(closed),
        .shutter_cmd_in(sh_cmd), .shutter_pos_in(sh_pos), .blower_on_in(bl_on),
        .blower_feedback_in(bl_fb), .airflow_fault_in(air), .lamp_start_in(start),
        .lamp_ready_in(ready), .cooldown_done_in(cool_done), .fault_clear_in(clear),
        .warn_out(warn), .fault_out(fault), .lamp_enable_out(lamp_en),
        .cooldown_out(cool), .alarm_out(alarm));
    task cyc(int n);
        repeat (n) @(negedge clk_in);
    endtask
    task chk(string nm, logic [8:0] seen, logic [8:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task end_sim;
        $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Bounded wait: a fault that never comes ends the run
    task wmask(logic [8:0] m);
        int i;
        for (i = 0; i < 9000 && (fault & m) == 9'h0; i++) cyc(1);
        if (i == 9000) begin
            n_fail++;
            end_sim();
        end
    endtask
    task clr;
        clear = 1;
        cyc(1);
        clear = 0;
        cyc(1);
        chk("cleared", fault, 9'h0);
    endtask
    task t_temp;
        int         sel [13] = '{0, 0, 0, 0, 1, 2, 2, 2, 2, 3, 3, 3, 3};
        int         val [13] = '{75, 76, 85, 86, 86, 65, 66, 75, 76, 110, 111, 120, 121};
        logic [2:0] w [13] = '{0, 4, 4, 4, 4, 0, 2, 2, 2, 0, 1, 1, 1};
        logic [8:0] f [13] = '{0, 0, 0, 9'h100, 9'h100, 0, 0, 0, 9'h080, 0, 0, 0, 9'h040};
        for (int i = 0; i < 13; i++) begin
            temp[sel[i]] = 10'(val[i]);
            cyc(1);
            chk("warn", 9'(warn), 9'(w[i]));
            chk("fault", fault, f[i]);
            temp[sel[i]] = (sel[i] == 3) ? 10'sd90 : 10'sd25;
            cyc(2);
            chk("latched", fault, f[i]);
            clr();
        end
        sp = 10'sd50;
        temp[3] = 10'sd61;
        cyc(1);
        chk("warn sp", 9'(warn), 9'h001);
        chk("fault sp", fault, 9'h000);
        temp[3] = 10'sd71;
        cyc(1);
        chk("fault sp2", fault, 9'h040);
        sp = 10'sd100;
        temp[3] = 10'sd90;
        cyc(1);
        clr();
    endtask
    task drv(int k, logic v);
        case (k)
            0: air = v;
            1: closed = !v;
            default: locked = !v;
        endcase
    endtask
    task t_timer(int k, int sh, logic [8:0] m);
        repeat (2) begin
            drv(k, 1);
            cyc(sh);
            drv(k, 0);
            cyc(1);
        end
        chk("short", fault, 9'h0);
        drv(k, 1);
        wmask(m);
        chk("timed", fault, m);
        drv(k, 0);
        cyc(20);
        clr();
    endtask
    task t_lamp_ok;
        bl_on = 1;
        sh_cmd = 1;
        start = 1;
        cyc(60);
        chk("run", fault, 9'h000);
        chk("run en", 9'(lamp_en), 9'h001);
        temp[2] = 10'sd70;
        cyc(3);
        chk("warn run", 9'({warn, lamp_en}), 9'h005);
        temp[2] = 10'sd25;
        start = 0;
        cyc(3);
        chk("stop", 9'({lamp_en, cool}), 9'h001);
        cool_done = 1;
        cyc(1);
        cool_done = 0;
        bl_on = 0;
        cyc(5);
        chk("idle", fault, 9'h000);
        chk("idle cool", 9'(cool), 9'h000);
    endtask
    task t_fb;
        lazy = 3'h6;
        bl_on = 1;
        sh_cmd = 0;
        wmask(9'h00c);
        cyc(25);
        chk("feedback", fault, 9'h00c);
        lazy = 3'h0;
        bl_on = 0;
        cyc(10);
        clr();
    endtask
    task t_warm;
        lazy = 3'h1;
        start = 1;
        cyc(2);
        chk("warming", 9'(lamp_en), 1);
        wmask(9'h001);
        chk("shut", fault, 9'h001);
        chk("shut out", 9'({lamp_en, alarm}), 9'h001);
        cyc(1);
        chk("cooling", 9'(cool), 1);
        start = 0;
        lazy = 3'h0;
        cool_done = 1;
        cyc(1);
        cool_done = 0;
        cyc(5);
        clr();
    endtask
    initial begin
        cyc(16);
        reset_n_in = 1;
        cyc(20);
        clr();
        t_temp();
        t_timer(0, 12, 9'h002);
        t_timer(1, 3, 9'h010);
        t_timer(2, 3, 9'h020);
        t_lamp_ok();
        t_fb();
        t_warm();
        end_sim();
    end
endmodule
